// file: boc_object_ctrl.v
// switchgear object controller: position decode, open/close commands, statistics
// assumes APB master on the system clock; status and request pins are asynchronous
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
`include "boc_regs.vh"

module boc_object_ctrl #(
    parameter TICK_CYC = `BOC_TICK_CYC
) (
    // clock and reset
    input  wire        MCLK_I,
    input  wire        SYS_RST_I,
    // apb slave
    input  wire        PSEL_I,
    input  wire        PENABLE_I,
    input  wire        PWRITE_I,
    input  wire [11:0] PADDR_I,
    input  wire [31:0] PWDATA_I,
    output reg  [31:0] PRDATA_O,
    output reg         PREADY_O,
    output reg         PSLVERR_O,
    // object status pins
    input  wire        OPEN_STATUS_I,
    input  wire        CLOSE_STATUS_I,
    input  wire        CART_INSERTED_INPUT_I,
    input  wire        CART_REMOVED_INPUT_I,
    input  wire        OBJECT_READY_I,
    input  wire        SYNC_PERMIT_I,
    // request sources
    input  wire        LOCAL_OPEN_I,
    input  wire        LOCAL_CLOSE_I,
    input  wire        REMOTE_OPEN_I,
    input  wire        REMOTE_CLOSE_I,
    input  wire        APP_OPEN_I,
    input  wire        APP_CLOSE_I,
    input  wire        OPEN_BLOCK_I,
    input  wire        CLOSE_BLOCK_I,
    input  wire        RECLOSE_EXPECTED_I,
    input  wire [1:0]  ACCESS_LEVEL_I,
    // relay and event outputs
    output reg         OUTPUT_RELAY_OPEN_O,
    output reg         OUTPUT_RELAY_CLOSE_O,
    output reg         FINAL_TRIP_O,
    output reg         CONTROL_ERROR_O
);
    localparam TW = 32;
    localparam S_IDLE = 2'h0;
    localparam S_OPEN = 2'h1;
    localparam S_CLOSE = 2'h2;

    // every pin and request passes a two-stage synchroniser
    localparam NSYNC = 13;
    wire [NSYNC-1:0] pin_raw = {OPEN_STATUS_I, CLOSE_STATUS_I, CART_INSERTED_INPUT_I,
                                CART_REMOVED_INPUT_I, OBJECT_READY_I, SYNC_PERMIT_I,
                                LOCAL_OPEN_I, LOCAL_CLOSE_I, REMOTE_OPEN_I, REMOTE_CLOSE_I,
                                APP_OPEN_I, APP_CLOSE_I, RECLOSE_EXPECTED_I};
    reg  [NSYNC-1:0] sync1_reg;
    reg  [NSYNC-1:0] sync2_reg;
    reg  [NSYNC-1:0] prev_reg;
    reg  [1:0]       blk1_reg;
    reg  [1:0]       blk2_reg;
    reg  [1:0]       lvl1_reg;
    reg  [1:0]       lvl2_reg;

    always @(posedge MCLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            sync1_reg <= {NSYNC{1'b0}};
            sync2_reg <= {NSYNC{1'b0}};
            prev_reg  <= {NSYNC{1'b0}};
            blk1_reg  <= 2'h0;
            blk2_reg  <= 2'h0;
            lvl1_reg  <= 2'h0;
            lvl2_reg  <= 2'h0;
        end else begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
            blk1_reg  <= {OPEN_BLOCK_I, CLOSE_BLOCK_I};
            blk2_reg  <= blk1_reg;
            lvl1_reg  <= ACCESS_LEVEL_I;
            lvl2_reg  <= lvl1_reg;
        end
    end

    wire st_open   = sync2_reg[12];
    wire st_close  = sync2_reg[11];
    wire cart_in   = sync2_reg[10];
    wire cart_out  = sync2_reg[9];
    wire ready_in  = sync2_reg[8];
    wire sync_in   = sync2_reg[7];
    wire reclose_x = sync2_reg[0];
    wire [NSYNC-1:0] rise = sync2_reg & ~prev_reg;

    // registers
    reg [31:0] ctrl_reg;
    reg [15:0] traverse_reg;
    reg [15:0] close_pulse_reg;
    reg [15:0] open_pulse_reg;
    reg [15:0] term_reg;
    reg [15:0] ftrip_len_reg;
    reg [31:0] open_ok_reg;
    reg [31:0] close_ok_reg;
    reg [31:0] open_fail_reg;
    reg [31:0] close_fail_reg;
    reg        clear_reg;
    reg        diag_open_reg;
    reg        diag_close_reg;
    reg        error_ev_reg;

    wire [1:0] obj_type = ctrl_reg[`BOC_CTRL_TYPE_LSB+1:`BOC_CTRL_TYPE_LSB];
    wire       apb_wr   = PSEL_I & PENABLE_I & PWRITE_I & PREADY_O;

    function addr_hit;
        input [11:0] a;
        input [11:0] ofs;
        begin
            addr_hit = (a == ofs);
        end
    endfunction

    // 20 ms tick from divider
    reg [TW-1:0] div_reg;
    wire tick = (div_reg == TICK_CYC - 1);
    always @(posedge MCLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I)
            div_reg <= {TW{1'b0}};
        else if (tick)
            div_reg <= {TW{1'b0}};
        else
            div_reg <= div_reg + 1'b1;
    end

    // position decode with traverse filtering
    reg [1:0]  pos_reg;
    reg [1:0]  cart_reg;
    reg [15:0] trav_cnt_reg;
    reg [1:0]  raw_prev_reg;
    wire [1:0] raw_pos = {st_close, st_open};
    always @(posedge MCLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            pos_reg      <= `BOC_ST_INTER;
            raw_prev_reg <= 2'h0;
            trav_cnt_reg <= 16'h0000;
            cart_reg     <= `BOC_ST_INTER;
        end else begin
            raw_prev_reg <= raw_pos;
            if (raw_pos != raw_prev_reg)
                trav_cnt_reg <= 16'h0000;
            else if (tick && trav_cnt_reg != 16'hFFFF)
                trav_cnt_reg <= trav_cnt_reg + 16'h0001;
            if (raw_pos == 2'b01 || raw_pos == 2'b10)
                pos_reg <= raw_pos;
            else if (trav_cnt_reg >= traverse_reg)
                pos_reg <= (raw_pos == 2'b11) ? `BOC_ST_BAD : `BOC_ST_INTER;
            if (obj_type == `BOC_TYPE_WD_CB)
                cart_reg <= {cart_in, cart_out};
            else
                cart_reg <= `BOC_ST_INTER;
        end
    end

    wire diag_ok = (lvl2_reg >= ctrl_reg[`BOC_CTRL_DIAG_LVL+1:`BOC_CTRL_DIAG_LVL]);
    wire req_open  = rise[6] | rise[4] | rise[2] | (diag_open_reg & diag_ok);
    wire req_close = rise[5] | rise[3] | rise[1] | (diag_close_reg & diag_ok);
    wire can_ctrl  = (obj_type != `BOC_TYPE_DISC_GND);
    wire is_cb     = (obj_type == `BOC_TYPE_WD_CB) || (obj_type == `BOC_TYPE_CB);
    wire sync_bad  = is_cb & ctrl_reg[`BOC_CTRL_SYNC_EN] & ~sync_in;
    wire rdy_bad   = is_cb & ctrl_reg[`BOC_CTRL_RDY_EN] &
                     (ready_in != ctrl_reg[`BOC_CTRL_RDY_POL]);
    wire open_blk  = blk2_reg[1];
    wire close_blk = blk2_reg[0];

    // command state machine
    reg [1:0]  state_reg;
    reg [15:0] pulse_cnt_reg;
    reg [15:0] tmo_cnt_reg;
    reg        pulse_on_reg;
    reg        ok_open_ev;
    reg        ok_close_ev;
    reg        fail_open_ev;
    reg        fail_close_ev;
    reg        trip_ev;
    always @(posedge MCLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            state_reg            <= S_IDLE;
            pulse_cnt_reg        <= 16'h0000;
            tmo_cnt_reg          <= 16'h0000;
            pulse_on_reg         <= 1'b0;
            OUTPUT_RELAY_OPEN_O  <= 1'b0;
            OUTPUT_RELAY_CLOSE_O <= 1'b0;
            ok_open_ev           <= 1'b0;
            ok_close_ev          <= 1'b0;
            fail_open_ev         <= 1'b0;
            fail_close_ev        <= 1'b0;
            trip_ev              <= 1'b0;
            error_ev_reg         <= 1'b0;
        end else begin
            ok_open_ev    <= 1'b0;
            ok_close_ev   <= 1'b0;
            fail_open_ev  <= 1'b0;
            fail_close_ev <= 1'b0;
            trip_ev       <= 1'b0;
            error_ev_reg  <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    pulse_cnt_reg <= 16'h0000;
                    tmo_cnt_reg   <= 16'h0000;
                    if (req_open) begin
                        if (!can_ctrl || open_blk)
                            fail_open_ev <= 1'b1;
                        else begin
                            state_reg           <= S_OPEN;
                            pulse_on_reg        <= 1'b1;
                            OUTPUT_RELAY_OPEN_O <= 1'b1;
                        end
                    end else if (req_close) begin
                        if (!can_ctrl || close_blk || sync_bad || rdy_bad)
                            fail_close_ev <= 1'b1;
                        else begin
                            state_reg            <= S_CLOSE;
                            pulse_on_reg         <= 1'b1;
                            OUTPUT_RELAY_CLOSE_O <= 1'b1;
                        end
                    end
                end
                S_OPEN, S_CLOSE: begin
                    if (tick) begin
                        pulse_cnt_reg <= pulse_cnt_reg + 16'h0001;
                        tmo_cnt_reg   <= tmo_cnt_reg + 16'h0001;
                    end
                    if (pulse_on_reg && tick && pulse_cnt_reg + 16'h0001 >=
                        ((state_reg == S_OPEN) ? open_pulse_reg : close_pulse_reg)) begin
                        pulse_on_reg         <= 1'b0;
                        OUTPUT_RELAY_OPEN_O  <= 1'b0;
                        OUTPUT_RELAY_CLOSE_O <= 1'b0;
                    end
                    if (pos_reg == ((state_reg == S_OPEN) ? `BOC_ST_OPEN : `BOC_ST_CLOSED)) begin
                        state_reg            <= S_IDLE;
                        pulse_on_reg         <= 1'b0;
                        OUTPUT_RELAY_OPEN_O  <= 1'b0;
                        OUTPUT_RELAY_CLOSE_O <= 1'b0;
                        ok_open_ev           <= (state_reg == S_OPEN);
                        ok_close_ev          <= (state_reg == S_CLOSE);
                        trip_ev              <= (state_reg == S_OPEN) & ~reclose_x;
                    end else if (tick && tmo_cnt_reg + 16'h0001 >= term_reg) begin
                        state_reg            <= S_IDLE;
                        pulse_on_reg         <= 1'b0;
                        OUTPUT_RELAY_OPEN_O  <= 1'b0;
                        OUTPUT_RELAY_CLOSE_O <= 1'b0;
                        error_ev_reg         <= 1'b1;
                        fail_open_ev         <= (state_reg == S_OPEN);
                        fail_close_ev        <= (state_reg == S_CLOSE);
                    end
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    // final trip stretcher
    reg [15:0] ftrip_cnt_reg;
    always @(posedge MCLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            FINAL_TRIP_O    <= 1'b0;
            ftrip_cnt_reg   <= 16'h0000;
            CONTROL_ERROR_O <= 1'b0;
        end else begin
            CONTROL_ERROR_O <= error_ev_reg;
            // zero length holds until a close
            if (trip_ev) begin
                FINAL_TRIP_O  <= 1'b1;
                ftrip_cnt_reg <= 16'h0000;
            end else if (FINAL_TRIP_O) begin
                if (ftrip_len_reg == 16'h0000) begin
                    if (ok_close_ev)
                        FINAL_TRIP_O <= 1'b0;
                end else if (tick) begin
                    ftrip_cnt_reg <= ftrip_cnt_reg + 16'h0001;
                    if (ftrip_cnt_reg + 16'h0001 >= ftrip_len_reg)
                        FINAL_TRIP_O <= 1'b0;
                end
            end
        end
    end

    // register writes, command bits self clear
    always @(posedge MCLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            ctrl_reg        <= `BOC_CTRL_RESET;
            traverse_reg    <= `BOC_TRAVERSE_RST;
            close_pulse_reg <= `BOC_PULSE_RST;
            open_pulse_reg  <= `BOC_PULSE_RST;
            term_reg        <= `BOC_TERM_RST;
            ftrip_len_reg   <= `BOC_FTRIP_RST;
            clear_reg       <= 1'b0;
            diag_open_reg   <= 1'b0;
            diag_close_reg  <= 1'b0;
        end else begin
            clear_reg      <= 1'b0;
            diag_open_reg  <= 1'b0;
            diag_close_reg <= 1'b0;
            if (apb_wr) begin
                if (addr_hit(PADDR_I, `BOC_OFS_CTRL))
                    ctrl_reg <= {25'h0, PWDATA_I[6:0]};
                if (addr_hit(PADDR_I, `BOC_OFS_TRAVERSE))
                    traverse_reg <= PWDATA_I[15:0];
                if (addr_hit(PADDR_I, `BOC_OFS_CLOSE_PULSE))
                    close_pulse_reg <= PWDATA_I[15:0];
                if (addr_hit(PADDR_I, `BOC_OFS_OPEN_PULSE))
                    open_pulse_reg <= PWDATA_I[15:0];
                if (addr_hit(PADDR_I, `BOC_OFS_TERM_TMO))
                    term_reg <= PWDATA_I[15:0];
                if (addr_hit(PADDR_I, `BOC_OFS_FTRIP_LEN))
                    ftrip_len_reg <= PWDATA_I[15:0];
                if (addr_hit(PADDR_I, `BOC_OFS_CMD)) begin
                    clear_reg      <= PWDATA_I[`BOC_CMD_CLEAR];
                    diag_open_reg  <= PWDATA_I[`BOC_CMD_DIAG_OPEN];
                    diag_close_reg <= PWDATA_I[`BOC_CMD_DIAG_CLOSE];
                end
            end
        end
    end

    // statistics; an event in the clear cycle still counts as one
    always @(posedge MCLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            open_ok_reg    <= 32'h0000_0000;
            close_ok_reg   <= 32'h0000_0000;
            open_fail_reg  <= 32'h0000_0000;
            close_fail_reg <= 32'h0000_0000;
        end else if (clear_reg) begin
            open_ok_reg    <= {31'h0, ok_open_ev};
            close_ok_reg   <= {31'h0, ok_close_ev};
            open_fail_reg  <= {31'h0, fail_open_ev};
            close_fail_reg <= {31'h0, fail_close_ev};
        end else begin
            open_ok_reg    <= open_ok_reg + {31'h0, ok_open_ev};
            close_ok_reg   <= close_ok_reg + {31'h0, ok_close_ev};
            open_fail_reg  <= open_fail_reg + {31'h0, fail_open_ev};
            close_fail_reg <= close_fail_reg + {31'h0, fail_close_ev};
        end
    end

    // apb read, one wait state, unmapped reads zero with error
    reg [31:0] rd_next;
    reg        hit_next;
    always @* begin
        rd_next  = 32'h0000_0000;
        hit_next = 1'b1;
        case (PADDR_I)
            `BOC_OFS_CTRL:        rd_next = ctrl_reg;
            `BOC_OFS_TRAVERSE:    rd_next = {16'h0, traverse_reg};
            `BOC_OFS_CLOSE_PULSE: rd_next = {16'h0, close_pulse_reg};
            `BOC_OFS_OPEN_PULSE:  rd_next = {16'h0, open_pulse_reg};
            `BOC_OFS_TERM_TMO:    rd_next = {16'h0, term_reg};
            `BOC_OFS_FTRIP_LEN:   rd_next = {16'h0, ftrip_len_reg};
            `BOC_OFS_STATUS:      rd_next = {23'h0, FINAL_TRIP_O, state_reg, ~rdy_bad,
                                             ~sync_bad, cart_reg, pos_reg};
            `BOC_OFS_OPEN_OK:     rd_next = open_ok_reg;
            `BOC_OFS_CLOSE_OK:    rd_next = close_ok_reg;
            `BOC_OFS_OPEN_FAIL:   rd_next = open_fail_reg;
            `BOC_OFS_CLOSE_FAIL:  rd_next = close_fail_reg;
            `BOC_OFS_CMD:         rd_next = 32'h0000_0000;
            `BOC_OFS_LEVEL:       rd_next = {30'h0, lvl2_reg};
            default:              hit_next = 1'b0;
        endcase
    end

    always @(posedge MCLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            PREADY_O  <= 1'b0;
            PRDATA_O  <= 32'h0000_0000;
            PSLVERR_O <= 1'b0;
        end else if (PSEL_I && PENABLE_I && !PREADY_O) begin
            PREADY_O  <= 1'b1;
            PRDATA_O  <= PWRITE_I ? 32'h0000_0000 : rd_next;
            PSLVERR_O <= ~hit_next;
        end else begin
            PREADY_O  <= 1'b0;
            PSLVERR_O <= 1'b0;
        end
    end
endmodule

// file: boc_regs.vh
// register map, field positions, reset values and timing counts of the object controller
// assumes a 50 MHz system clock; included by the controller and the bench
`ifndef BOC_REGS_VH
`define BOC_REGS_VH
`define BOC_CLK_HZ          50000000
`define BOC_TICK_MS         20
`define BOC_TICK_CYC        ((`BOC_CLK_HZ / 1000) * `BOC_TICK_MS)
`define BOC_BLOCK_LEAD_MS   5
`define BOC_BLOCK_LEAD_CYC  ((`BOC_CLK_HZ / 1000) * `BOC_BLOCK_LEAD_MS)
`define BOC_OFS_CTRL        12'h000
`define BOC_OFS_TRAVERSE    12'h004
`define BOC_OFS_CLOSE_PULSE 12'h008
`define BOC_OFS_OPEN_PULSE  12'h00C
`define BOC_OFS_TERM_TMO    12'h010
`define BOC_OFS_FTRIP_LEN   12'h014
`define BOC_OFS_STATUS      12'h018
`define BOC_OFS_OPEN_OK     12'h01C
`define BOC_OFS_CLOSE_OK    12'h020
`define BOC_OFS_OPEN_FAIL   12'h024
`define BOC_OFS_CLOSE_FAIL  12'h028
`define BOC_OFS_CMD         12'h02C
`define BOC_OFS_LEVEL       12'h030
`define BOC_CTRL_TYPE_LSB   0
`define BOC_CTRL_SYNC_EN    2
`define BOC_CTRL_RDY_EN     3
`define BOC_CTRL_RDY_POL    4
`define BOC_CTRL_DIAG_LVL   5
`define BOC_CTRL_RESET      32'h0000_0041
`define BOC_CMD_CLEAR       0
`define BOC_CMD_DIAG_OPEN   1
`define BOC_CMD_DIAG_CLOSE  2
`define BOC_TYPE_WD_CB      2'h0
`define BOC_TYPE_CB         2'h1
`define BOC_TYPE_DISC_MC    2'h2
`define BOC_TYPE_DISC_GND   2'h3
`define BOC_LVL_CONFIG      2'h2
`define BOC_ST_INTER        2'h0
`define BOC_ST_OPEN         2'h1
`define BOC_ST_CLOSED       2'h2
`define BOC_ST_BAD          2'h3
`define BOC_TRAVERSE_RST    16'h000A
`define BOC_PULSE_RST       16'h000A
`define BOC_TERM_RST        16'h01F4
`define BOC_FTRIP_RST       16'h000A
`endif

// file: boc_object_ctrl_assertions.sv
// port checks on the object controller
// bound into boc_object_ctrl; pulse limit assumes default settings
`timescale 1ns/10ps
module boc_object_ctrl_assertions #(
    parameter int TICK_CYC = 10
) (
    input wire MCLK_I,
    input wire SYS_RST_I,
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PREADY_O,
    input wire PSLVERR_O,
    input wire OPEN_STATUS_I,
    input wire CLOSE_STATUS_I,
    input wire OUTPUT_RELAY_OPEN_O,
    input wire OUTPUT_RELAY_CLOSE_O,
    input wire FINAL_TRIP_O,
    input wire CONTROL_ERROR_O
);
    // one spare tick: pulse start is not aligned to the tick
    localparam int LIM = 11 * TICK_CYC + 4;
    logic [31:0] n_rl_reg;
    always @(posedge MCLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I)
            n_rl_reg <= 32'h0;
        else
            n_rl_reg <= (OUTPUT_RELAY_OPEN_O || OUTPUT_RELAY_CLOSE_O) ? n_rl_reg + 1 : 32'h0;
    end
    default clocking dc @(posedge MCLK_I); endclocking
    default disable iff (SYS_RST_I);
    a_relay_excl: assert property (!(OUTPUT_RELAY_OPEN_O && OUTPUT_RELAY_CLOSE_O))
        else $error("both relays energised");
    a_pulse_max: assert property (n_rl_reg <= LIM)
        else $error("command pulse too long");
    a_ready_one: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready longer than one cycle");
    a_ready_wait: assert property (PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O)
        else $error("ready not after one wait state");
    a_err_ready: assert property (PSLVERR_O |-> PREADY_O)
        else $error("slave error without ready");
    a_err_pulse: assert property (CONTROL_ERROR_O |=> !CONTROL_ERROR_O)
        else $error("error event not a pulse");
    a_close_early: assert property ($rose(CLOSE_STATUS_I) && OUTPUT_RELAY_CLOSE_O
        |-> ##[1:8] !OUTPUT_RELAY_CLOSE_O) else $error("close pulse not ended");
    a_open_early: assert property ($rose(OPEN_STATUS_I) && OUTPUT_RELAY_OPEN_O
        |-> ##[1:8] !OUTPUT_RELAY_OPEN_O) else $error("open pulse not ended");
    c_close: cover property ($rose(OUTPUT_RELAY_CLOSE_O));
    c_error: cover property (CONTROL_ERROR_O);
    c_trip: cover property ($rose(FINAL_TRIP_O));
endmodule

bind boc_object_ctrl boc_object_ctrl_assertions #(.TICK_CYC(TICK_CYC)) u_chk (
    .MCLK_I, .SYS_RST_I, .PSEL_I, .PENABLE_I, .PREADY_O, .PSLVERR_O, .OPEN_STATUS_I,
    .CLOSE_STATUS_I, .OUTPUT_RELAY_OPEN_O, .OUTPUT_RELAY_CLOSE_O, .FINAL_TRIP_O,
    .CONTROL_ERROR_O
);

// file: boc_breaker_model.sv
// breaker with auxiliary contacts, moved by the relay outputs
// driven by the bench; stuck_i and fault_i only when a test asks
`timescale 1ns/10ps
module boc_breaker_model #(
    parameter int DELAY = 20
) (
    input  wire       clk_i,
    input  wire       rl_open_i,
    input  wire       rl_close_i,
    input  wire       stuck_i,
    input  wire [1:0] fault_i,
    output wire       open_st_o,
    output wire       close_st_o
);
    logic       pos_reg = 1'b0;
    logic [7:0] cnt_reg = 8'h00;
    // contacts active high; fault 1 both, 2 none
    assign open_st_o  = fault_i == 2'h1 || (fault_i == 2'h0 && !pos_reg);
    assign close_st_o = fault_i == 2'h1 || (fault_i == 2'h0 && pos_reg);
    // coil must stay energised for DELAY+1 cycles before it moves
    always @(posedge clk_i) begin
        if (!stuck_i && (rl_close_i && !pos_reg || rl_open_i && pos_reg)) begin
            cnt_reg <= cnt_reg + 8'h01;
            if (cnt_reg == 8'(DELAY))
                pos_reg <= rl_close_i;
        end else
            cnt_reg <= 8'h00;
    end
endmodule

// file: boc_object_ctrl_tb_top.sv
// bench for the object controller with a breaker model
// short tick in simulation; ends with one verdict line
`timescale 1ns/10ps
`include "boc_regs.vh"
module boc_object_ctrl_tb_top;
    localparam int          TK = 10;
    localparam logic [31:0] CB = `BOC_CTRL_RESET;
    localparam logic [44:0] ROWS [8] = '{{1'b0, `BOC_OFS_CTRL, CB},
        {1'b0, `BOC_OFS_TRAVERSE, 16'h0, `BOC_TRAVERSE_RST},
        {1'b0, `BOC_OFS_CLOSE_PULSE, 16'h0, `BOC_PULSE_RST},
        {1'b0, `BOC_OFS_OPEN_PULSE, 16'h0, `BOC_PULSE_RST},
        {1'b0, `BOC_OFS_TERM_TMO, 16'h0, `BOC_TERM_RST},
        {1'b0, `BOC_OFS_FTRIP_LEN, 16'h0, `BOC_FTRIP_RST},
        {1'b0, `BOC_OFS_LEVEL, 30'h0, `BOC_LVL_CONFIG}, {1'b1, 12'h034, 32'h0}};
    logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, er, stuck = 0, rcl = 1;
    logic        rdy = 0, syn = 0;
    logic [11:0] pa = 12'h000;
    logic [31:0] pw = 32'h0, rd, ex [4] = '{0, 0, 0, 0};
    logic [5:0]  req = 6'h00;
    logic [1:0]  flt = 2'h0, lvl = 2'h2;
    wire  [31:0] prd;
    wire         prdy, perr, st_o, st_c, rl_o, rl_c, ftrip, cerr;
    wire  [3:0]  mon = {cerr, ftrip, rl_c, rl_o};
    int          n_fail = 0, compares = 0;
    boc_object_ctrl #(.TICK_CYC(TK)) uut (.MCLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pw), .PRDATA_O(prd),
        .PREADY_O(prdy), .PSLVERR_O(perr), .OPEN_STATUS_I(st_o), .CLOSE_STATUS_I(st_c),
        .CART_INSERTED_INPUT_I(1'b0), .CART_REMOVED_INPUT_I(1'b0), .OBJECT_READY_I(rdy),
        .SYNC_PERMIT_I(syn), .LOCAL_OPEN_I(req[0]), .LOCAL_CLOSE_I(req[1]),
        .REMOTE_OPEN_I(req[2]), .REMOTE_CLOSE_I(req[3]), .APP_OPEN_I(req[4]),
        .APP_CLOSE_I(req[5]), .OPEN_BLOCK_I(1'b0), .CLOSE_BLOCK_I(1'b0),
        .RECLOSE_EXPECTED_I(rcl), .ACCESS_LEVEL_I(lvl), .OUTPUT_RELAY_OPEN_O(rl_o),
        .OUTPUT_RELAY_CLOSE_O(rl_c), .FINAL_TRIP_O(ftrip), .CONTROL_ERROR_O(cerr));
    boc_breaker_model u_brk (.clk_i(clk), .rl_open_i(rl_o), .rl_close_i(rl_c),
        .stuck_i(stuck), .fault_i(flt), .open_st_o(st_o), .close_st_o(st_c));
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic close_out();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_sig(input int k, input logic v, input int n);
        int i;
        for (i = 0; i < n && mon[k] !== v; i++)
            @(posedge clk);
        if (i == n) begin
            n_fail++;
            $display("[FAIL] %0t no change on output %0d", $time, k);
            close_out();
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        {psel, pen, pwr, pa, pw} <= {2'b10, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        for (i = 0; i < 20 && prdy !== 1'b1; i++)
            @(posedge clk);
        {rd, er} = {prd, perr};
        {psel, pen} <= 2'b00;
        if (i == 20)
            wait_sig(0, ~rl_o, 0);
    endtask
    task automatic pulse(input int k);
        @(posedge clk);
        req[k] <= 1'b1;
        repeat (4) @(posedge clk);
        req[k] <= 1'b0;
    endtask
    task automatic move(input int k, input int r);
        pulse(k);
        wait_sig(r, 1'b1, 20);
        wait_sig(r, 1'b0, 60);
    endtask
    task automatic quiet(input int r);
        repeat (30) @(posedge clk);
        chk({31'h0, mon[r]}, 32'h0);
    endtask
    task automatic cnt_all();
        for (int k = 0; k < 4; k++) begin
            apb(1'b0, `BOC_OFS_OPEN_OK + 12'(4 * k), 32'h0);
            chk(rd, ex[k]);
        end
    endtask
    task automatic st_chk(input logic [1:0] e);
        apb(1'b0, `BOC_OFS_STATUS, 32'h0);
        chk({30'h0, rd[1:0]}, {30'h0, e});
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        foreach (ROWS[k]) begin
            apb(1'b0, ROWS[k][43:32], 32'h0);
            chk({31'h0, er}, {31'h0, ROWS[k][44]});
            chk(rd, ROWS[k][31:0]);
        end
        cnt_all();
        st_chk(`BOC_ST_OPEN);
        move(1, 1);
        st_chk(`BOC_ST_CLOSED);
        move(2, 0);
        quiet(2);
        rcl <= 1'b0;
        move(5, 1);
        move(4, 0);
        wait_sig(2, 1'b1, 20);
        wait_sig(2, 1'b0, 130);
        apb(1'b1, `BOC_OFS_CTRL, CB | 32'h4);
        pulse(5);
        quiet(1);
        apb(1'b1, `BOC_OFS_CTRL, CB | 32'h1C);
        syn <= 1'b1;
        pulse(3);
        quiet(1);
        rdy <= 1'b1;
        move(3, 1);
        ex = '{2, 3, 0, 2};
        cnt_all();
        stuck <= 1'b1;
        pulse(0);
        wait_sig(0, 1'b1, 20);
        wait_sig(0, 1'b0, 120);
        wait_sig(3, 1'b1, 5200);
        {stuck, flt} <= 3'b001;
        repeat (130) @(posedge clk);
        st_chk(`BOC_ST_BAD);
        flt <= 2'h2;
        repeat (130) @(posedge clk);
        st_chk(`BOC_ST_INTER);
        flt <= 2'h0;
        apb(1'b1, `BOC_OFS_CTRL, CB | 32'h2);
        pulse(0);
        quiet(0);
        apb(1'b1, `BOC_OFS_CTRL, 32'h46);
        syn <= 1'b0;
        move(0, 0);
        move(1, 1);
        apb(1'b1, `BOC_OFS_CTRL, CB);
        lvl <= 2'h1;
        apb(1'b1, `BOC_OFS_CMD, 32'h2);
        quiet(0);
        lvl <= 2'h2;
        repeat (5) @(posedge clk);
        apb(1'b1, `BOC_OFS_CMD, 32'h2);
        wait_sig(0, 1'b1, 20);
        wait_sig(0, 1'b0, 60);
        apb(1'b1, `BOC_OFS_CMD, 32'h1);
        move(1, 1);
        ex = '{0, 1, 0, 0};
        cnt_all();
        close_out();
    end
endmodule
